// ### hdl/plr_pkg.sv
/*
  Constants, state codes and the state record of the link-side request sender.
  Assumes one 50 MHz clock shared with the device's interface clock domain view.
*/
package plr_pkg;
    // ------------------------------------------------------------
    // request type codes
    // ------------------------------------------------------------
    localparam logic [2:0] REQ_IMM = 3'h0;
    localparam logic [2:0] REQ_ISO = 3'h1;
    localparam logic [2:0] REQ_PRI = 3'h2;
    localparam logic [2:0] REQ_FAIR = 3'h3;
    localparam logic [2:0] REQ_READ = 3'h4;
    localparam logic [2:0] REQ_WRITE = 3'h5;
    localparam logic [2:0] REQ_ACCEL = 3'h6;
    localparam logic [2:0] REQ_RSVD = 3'h7;
    // ------------------------------------------------------------
    // speed codes
    // ------------------------------------------------------------
    localparam logic [2:0] SPD_S100 = 3'h0;
    localparam logic [2:0] SPD_S200 = 3'h2;
    localparam logic [2:0] SPD_S400 = 3'h4;
    // ------------------------------------------------------------
    // stream lengths
    // ------------------------------------------------------------
    localparam int FRAME_W = 17;
    localparam logic [4:0] LEN_BUS_SHORT = 5'h07;
    localparam logic [4:0] LEN_BUS = 5'h08;
    localparam logic [4:0] LEN_READ = 5'h09;
    localparam logic [4:0] LEN_WRITE = 5'h11;
    localparam logic [4:0] LEN_ACCEL = 5'h06;
    // ------------------------------------------------------------
    // control bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] CTL_IDLE = 2'h0;
    localparam logic [1:0] CTL_STATUS = 2'h1;
    localparam logic [1:0] CTL_RECEIVE = 2'h2;
    localparam logic [1:0] CTL_GRANT = 2'h3;
    localparam logic [1:0] LCTL_RELEASE = 2'h0;
    localparam logic [1:0] LCTL_HOLD = 2'h1;
    localparam logic [1:0] LCTL_TRANSMIT = 2'h2;
    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] GRANT_BLANK = 2'h3;
    localparam logic [1:0] RST_SYNC_ISO = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_SEND = 2'h3
    } plr_state_t;

    typedef struct packed {
        plr_state_t state;
        logic [FRAME_W-1:0] frame;
        logic [FRAME_W-1:0] sh;
        logic [4:0] len;
        logic [4:0] cnt;
        logic [2:0] kind;
        logic retry;
        logic pending;
        logic [2:0] pend_kind;
        logic iso_ok;
        logic [1:0] ctl_s1;
        logic [1:0] ctl_s2;
        logic [1:0] flt_s1;
        logic [1:0] flt_s2;
        logic [1:0] iso_s;
        logic [1:0] ctl_h;
        logic idle_prev;
        logic owned;
        logic [1:0] blank;
        logic line;
        logic line_oe_n;
        logic [1:0] ctl_out;
        logic [1:0] ctl_oe_n;
        logic [7:0] dat_out;
        logic [7:0] dat_oe_n;
        logic ready;
    } plr_reg_t;
endpackage

// ### hdl/plr_link_requester.sv
/*
  Link-side request sender: serialises service requests onto the request line,
  tracks the pending bus request, takes and releases the interface on grant,
  and differentiates its outputs when the isolation select is low.
  Assumes the pins are resolved outside from the output enables and the float flags.
*/
module plr_link_requester (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // user request port
    input wire logic req_valid_i,
    input wire logic [2:0] req_type_i,
    input wire logic [2:0] req_speed_i,
    input wire logic [3:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    input wire logic req_accel_i,
    output logic req_ready_o,
    output logic bus_pending_o,
    // user events and transmit side
    input wire logic cycle_start_i,
    input wire logic bus_reset_i,
    input wire logic crc_bad_i,
    input wire logic [1:0] tx_ctl_i,
    input wire logic [7:0] tx_data_i,
    output logic granted_o,
    // interface pins
    input wire logic iso_mode_n_i,
    output logic link_request_line_o,
    output logic link_request_line_oe_n_o,
    input wire logic [1:0] interface_control_bus_i,
    input wire logic [1:0] interface_control_bus_float_i,
    output logic [1:0] interface_control_bus_o,
    output logic [1:0] interface_control_bus_oe_n_o,
    output logic [7:0] interface_data_bus_o,
    output logic [7:0] interface_data_bus_oe_n_o
);
    import plr_pkg::*;

    plr_reg_t st;
    plr_reg_t next_st;
    logic iso_on;
    logic seen_rx;
    logic seen_grant;
    logic fairpri;
    logic allowed;

    // low when the pin is to be driven this cycle
    function automatic logic drive_n(input logic on, input logic own_nx, input logic own_now,
                                     input logic lvl_nx, input logic lvl_now);
        return !(own_nx && (!on || !own_now || (lvl_nx != lvl_now)));
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        iso_on = !st.iso_s[1];
        next_st.ctl_s1 = interface_control_bus_i;
        next_st.ctl_s2 = st.ctl_s1;
        next_st.flt_s1 = interface_control_bus_float_i;
        next_st.flt_s2 = st.flt_s1;
        next_st.iso_s = {st.iso_s[0], iso_mode_n_i};
        for (int i = 0; i < 2; i++) begin
            next_st.ctl_h[i] = st.flt_s2[i] ? st.ctl_h[i] : st.ctl_s2[i];
        end
        next_st.idle_prev = (st.ctl_h == CTL_IDLE);
        // device codes only mean something while the device owns the bus
        seen_rx = !st.owned && (st.ctl_h == CTL_RECEIVE);
        seen_grant = !st.owned && (st.blank == 2'h0) && (st.ctl_h == CTL_GRANT);
        fairpri = (st.kind == REQ_PRI) || (st.kind == REQ_FAIR);
        unique case (st.kind)
            REQ_PRI, REQ_FAIR: allowed = (st.ctl_h == CTL_IDLE) && st.idle_prev;
            REQ_ISO: allowed = st.iso_ok;
            default: allowed = 1'b1;
        endcase
        if (st.blank != 2'h0) begin
            next_st.blank = st.blank - 2'h1;
        end
        // pending bus request: clears first so that a set in the same cycle wins
        if (seen_grant || bus_reset_i) begin
            next_st.pending = 1'b0;
        end
        if (seen_rx && ((st.pend_kind == REQ_PRI) || (st.pend_kind == REQ_FAIR))) begin
            next_st.pending = 1'b0;
        end
        unique case (st.state)
            ST_IDLE: begin
                if (req_valid_i && st.ready) begin
                    next_st.kind = req_type_i;
                    next_st.state = ST_WAIT;
                    unique case (req_type_i)
                        REQ_READ: begin
                            next_st.frame = {1'b1, req_type_i, req_addr_i, 1'b0, 8'h00};
                            next_st.len = LEN_READ;
                        end
                        REQ_WRITE: begin
                            next_st.frame = {1'b1, req_type_i, req_addr_i, req_data_i, 1'b0};
                            next_st.len = LEN_WRITE;
                        end
                        REQ_ACCEL: begin
                            next_st.frame = {1'b1, req_type_i, req_accel_i, 1'b0, 11'h000};
                            next_st.len = LEN_ACCEL;
                        end
                        REQ_RSVD: begin
                            next_st.state = ST_IDLE;
                        end
                        default: begin
                            // speed code goes out as given, invalid ones included
                            next_st.frame = {1'b1, req_type_i, req_speed_i, 1'b0, 9'h000};
                            next_st.len = req_speed_i[0] ? LEN_BUS : LEN_BUS_SHORT;
                            if (st.pending) begin
                                next_st.state = ST_IDLE;
                            end
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                if (allowed) begin
                    next_st.line = st.frame[FRAME_W-1];
                    next_st.sh = st.frame << 1;
                    next_st.cnt = st.len - 5'h01;
                    next_st.retry = 1'b0;
                    next_st.state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (fairpri && seen_rx) begin
                    next_st.retry = 1'b1;
                end
                if (st.cnt == 5'h00) begin
                    next_st.line = 1'b0;
                    if (st.retry || (fairpri && seen_rx)) begin
                        next_st.state = ST_WAIT;
                    end else begin
                        next_st.state = ST_IDLE;
                        if (!st.kind[2]) begin
                            next_st.pending = 1'b1;
                            next_st.pend_kind = st.kind;
                        end
                        if (st.kind == REQ_ISO) begin
                            next_st.iso_ok = 1'b0;
                        end
                    end
                end else begin
                    next_st.line = st.sh[FRAME_W-1];
                    next_st.sh = st.sh << 1;
                    next_st.cnt = st.cnt - 5'h01;
                end
            end
        endcase
        if (cycle_start_i) begin
            next_st.iso_ok = 1'b1;
        end
        next_st.ready = (next_st.state == ST_IDLE);
        // interface ownership after a grant
        if (seen_grant) begin
            next_st.owned = 1'b1;
            next_st.ctl_out = crc_bad_i ? LCTL_RELEASE : tx_ctl_i;
        end else if (st.owned) begin
            if (st.ctl_out == LCTL_RELEASE) begin
                next_st.owned = 1'b0;
                next_st.ctl_out = LCTL_RELEASE;
                next_st.blank = GRANT_BLANK;
            end else begin
                next_st.ctl_out = tx_ctl_i;
            end
        end
        next_st.dat_out = next_st.owned ? tx_data_i : 8'h00;
        next_st.line_oe_n = drive_n(iso_on, 1'b1, 1'b1, next_st.line, st.line);
        for (int i = 0; i < 2; i++) begin
            next_st.ctl_oe_n[i] = drive_n(iso_on, next_st.owned, st.owned,
                                          next_st.ctl_out[i], st.ctl_out[i]);
        end
        for (int i = 0; i < 8; i++) begin
            next_st.dat_oe_n[i] = drive_n(iso_on, next_st.owned, st.owned,
                                          next_st.dat_out[i], st.dat_out[i]);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.iso_s <= RST_SYNC_ISO;
            st.line_oe_n <= 1'b0;
            st.ctl_oe_n <= 2'h3;
            st.dat_oe_n <= 8'hFF;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign req_ready_o = st.ready;
    assign bus_pending_o = st.pending;
    assign granted_o = st.owned;
    assign link_request_line_o = st.line;
    assign link_request_line_oe_n_o = st.line_oe_n;
    assign interface_control_bus_o = st.ctl_out;
    assign interface_control_bus_oe_n_o = st.ctl_oe_n;
    assign interface_data_bus_o = st.dat_out;
    assign interface_data_bus_oe_n_o = st.dat_oe_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    line_rests_low_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (st.state == ST_IDLE) |-> !link_request_line_o)
        else $error("request line not low while idle");
    start_bit_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(st.state == ST_SEND) |-> link_request_line_o)
        else $error("stream without start bit");
    type_bits_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(st.state == ST_SEND) |-> ##1 (link_request_line_o == st.kind[2])
        ##1 (link_request_line_o == st.kind[1]) ##1 (link_request_line_o == st.kind[0]))
        else $error("type bits wrong");
    accel_length_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ($rose(st.state == ST_SEND) && (st.kind == REQ_ACCEL))
        |-> (st.state == ST_SEND) [*6] ##1 (st.state != ST_SEND))
        else $error("acceleration stream length wrong");
    diff_pulse_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!st.iso_s[1] && $past(!st.iso_s[1]) && $changed(link_request_line_o))
        |-> !link_request_line_oe_n_o)
        else $error("level change not driven");
    diff_float_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!st.iso_s[1] && $past(!st.iso_s[1]) && $stable(link_request_line_o))
        |-> link_request_line_oe_n_o)
        else $error("steady level not floated");
    plain_drive_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ($past(st.iso_s[1]) && $past(st.iso_s[1], 2)) |-> !link_request_line_oe_n_o)
        else $error("request line not driven outside isolated mode");
    idle_first_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ($rose(st.state == ST_SEND) && ((st.kind == REQ_PRI) || (st.kind == REQ_FAIR)))
        |-> ($past(st.ctl_h) == CTL_IDLE) && ($past(st.ctl_h, 2) == CTL_IDLE))
        else $error("fair or priority request sent too soon after idle");
    cancel_release_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (seen_grant && crc_bad_i)
        |=> (granted_o && (interface_control_bus_o == LCTL_RELEASE)) ##1 !granted_o)
        else $error("cancelled acknowledge not released at once");
endmodule

// ### bench/plr_phy_model.sv
/*
  Device-side model: decodes request streams, keeps the pending bus request,
  a register file and the acceleration flag, and drives the control bus.
  Assumes the bench resolves the wires and drives rx_i and win_i.
*/
module plr_phy_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // resolved wires and bench controls
    input wire logic line_i,
    input wire logic [1:0] ctl_i,
    input wire logic rx_i,
    input wire logic win_i,
    input wire logic bus_reset_i,
    // device drive and decode results
    output logic [1:0] ctl_o,
    output logic drv_o,
    output logic [16:0] bits_o,
    output logic [4:0] len_o,
    output logic [7:0] cnt_o,
    output logic pend_o,
    output logic accel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import plr_pkg::*;
    logic busy;
    logic [4:0] n;
    logic [4:0] len;
    logic [16:0] sh;
    logic [2:0] kind;
    logic [2:0] pkind;
    logic [1:0] gnt;
    logic [7:0] regs [16];
    logic [16:0] nsh;
    logic [4:0] nn;
    logic done;
    logic ovl;
    assign nsh = {sh[15:0], line_i};
    assign nn = n + 5'h01;
    // short bus form ends after the speed field when its last bit is low
    assign done = (nn == len) || (nn == LEN_BUS_SHORT && !nsh[5] && !nsh[0]);
    assign drv_o = (gnt != 2'h2);
    assign ctl_o = rx_i ? CTL_RECEIVE : (gnt == 2'h1) ? CTL_GRANT : CTL_IDLE;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            busy <= 1'b0;
            gnt <= 2'h0;
            pend_o <= 1'b0;
            cnt_o <= 8'h00;
            accel_o <= 1'b0;
        end else begin
            if (rx_i && pend_o && pkind[1]) pend_o <= 1'b0;
            if (bus_reset_i) pend_o <= 1'b0;
            if (win_i && pend_o) begin
                pend_o <= 1'b0;
                gnt <= 2'h1;
            end
            if (gnt == 2'h1) gnt <= 2'h2;
            if (gnt == 2'h2 && ctl_i == LCTL_RELEASE) gnt <= 2'h0;
            if (!busy) begin
                busy <= line_i;
                sh <= 17'h00001;
                ovl <= 1'b0;
                n <= 5'h01;
                len <= LEN_WRITE;
            end else begin
                sh <= nsh;
                n <= nn;
                // receive at any point after the start bit spoils a fair or priority request
                if (rx_i) ovl <= 1'b1;
                if (nn == 5'h04) begin
                    kind <= nsh[2:0];
                    case (nsh[2:0])
                        REQ_READ: len <= LEN_READ;
                        REQ_WRITE: len <= LEN_WRITE;
                        REQ_ACCEL: len <= LEN_ACCEL;
                        REQ_RSVD: busy <= 1'b0;
                        default: len <= LEN_BUS;
                    endcase
                end
                if (done) begin
                    busy <= 1'b0;
                    bits_o <= nsh;
                    len_o <= nn;
                    cnt_o <= cnt_o + 8'h01;
                    if (kind == REQ_WRITE) regs[nsh[12:9]] <= nsh[8:1];
                    if (kind == REQ_ACCEL) accel_o <= nsh[1];
                    if (!kind[2] && !pend_o && !(kind[1] && (ovl || rx_i))) begin
                        pend_o <= 1'b1;
                        pkind <= kind;
                    end
                end
            end
        end
    end
endmodule

// ### bench/tb_top.sv
/*
  Self-checking bench for the request sender against the device model.
  Assumes one 50 MHz clock; wires held by hysteresis when nobody drives.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import plr_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid = 1'b0;
    logic [2:0] req_type = 3'h0;
    logic [2:0] req_speed = 3'h0;
    logic [3:0] req_addr = 4'h0;
    logic [7:0] req_data = 8'h00;
    logic req_accel = 1'b0;
    logic cyc_start = 1'b0;
    logic bus_rst = 1'b0;
    logic crc_bad = 1'b0;
    logic [1:0] tx_ctl = 2'h0;
    logic [7:0] tx_data = 8'h5A;
    logic iso_n = 1'b1;
    logic rx = 1'b0;
    logic win = 1'b0;
    logic mon_on = 1'b0;
    logic line_prev = 1'b0;
    logic line_h = 1'b0;
    logic [1:0] ctl_h = 2'h0;
    logic ready, pending, granted, line_o, line_oe_n, m_drv, m_pend, m_accel, line_w;
    logic [1:0] ctl_o, ctl_oe_n, m_ctl, ctl_w, m_float;
    logic [7:0] dat_o, dat_oe_n, m_cnt;
    logic [16:0] m_bits;
    logic [4:0] m_len;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // ------------
    // clock, wires
    // ------------
    always #10 sys_clk_i = ~sys_clk_i;
    // released wires keep their last level
    assign line_w = line_oe_n ? line_h : line_o;
    assign m_float = ctl_oe_n & {2{~m_drv}};
    assign ctl_w = (~ctl_oe_n & ctl_o) | (ctl_oe_n & (m_drv ? m_ctl : ctl_h));
    always @(posedge sys_clk_i) begin
        line_h <= line_w;
        ctl_h <= ctl_w;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    plr_link_requester dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid), .req_type_i(req_type), .req_speed_i(req_speed),
        .req_addr_i(req_addr), .req_data_i(req_data), .req_accel_i(req_accel),
        .req_ready_o(ready), .bus_pending_o(pending), .cycle_start_i(cyc_start),
        .bus_reset_i(bus_rst), .crc_bad_i(crc_bad), .tx_ctl_i(tx_ctl), .tx_data_i(tx_data),
        .granted_o(granted), .iso_mode_n_i(iso_n), .link_request_line_o(line_o),
        .link_request_line_oe_n_o(line_oe_n), .interface_control_bus_i(ctl_w),
        .interface_control_bus_float_i(m_float), .interface_control_bus_o(ctl_o),
        .interface_control_bus_oe_n_o(ctl_oe_n), .interface_data_bus_o(dat_o),
        .interface_data_bus_oe_n_o(dat_oe_n));
    plr_phy_model phy_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .line_i(line_w),
        .ctl_i(ctl_w), .rx_i(rx), .win_i(win), .bus_reset_i(bus_rst), .ctl_o(m_ctl),
        .drv_o(m_drv), .bits_o(m_bits), .len_o(m_len), .cnt_o(m_cnt), .pend_o(m_pend),
        .accel_o(m_accel));
    // ------------
    // tasks
    // ------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // request line drives only on level changes while isolated
    always @(negedge sys_clk_i) begin
        if (mon_on) chk(17'(line_oe_n), 17'(!iso_n && line_o === line_prev));
        line_prev <= line_o;
    end
    task automatic send(input logic [2:0] t, input logic [2:0] s, input logic [3:0] a,
                        input logic [7:0] d, input logic ac, input int rxn);
        int i;
        req_type = t;
        req_speed = s;
        req_addr = a;
        req_data = d;
        req_accel = ac;
        req_valid = 1'b1;
        @(negedge sys_clk_i);
        req_valid = 1'b0;
        rx = (rxn > 0);
        for (i = 0; i < rxn; i++) @(negedge sys_clk_i);
        rx = 1'b0;
        for (i = 0; i < 200 && ready !== 1'b1; i++) @(negedge sys_clk_i);
        repeat (2) @(negedge sys_clk_i);
    endtask
    task automatic grant(input logic bad);
        int i;
        crc_bad = bad;
        tx_ctl = LCTL_HOLD;
        win = 1'b1;
        @(negedge sys_clk_i);
        win = 1'b0;
        for (i = 0; i < 20 && granted !== 1'b1; i++) @(negedge sys_clk_i);
        chk(17'(ctl_o), 17'(bad ? LCTL_RELEASE : LCTL_HOLD));
        chk(17'(ctl_oe_n), 17'h0);
        if (!bad) chk(17'(dat_o), 17'(tx_data));
        tx_ctl = LCTL_RELEASE;
        for (i = 0; i < 20 && granted !== 1'b0; i++) @(negedge sys_clk_i);
        repeat (5) @(negedge sys_clk_i);
        chk(17'({pending, m_pend, granted}), 17'h0);
    endtask
    // ------------
    // scenarios
    // ------------
    task automatic t_regs;
        for (int a = 0; a < 2; a++) begin
            send(REQ_ACCEL, 3'h0, 4'h0, 8'h00, a[0], 0);
            chk(m_bits, {11'h0, 1'b1, REQ_ACCEL, a[0], 1'b0});
            chk(17'({m_len, m_accel}), 17'({LEN_ACCEL, a[0]}));
        end
        send(REQ_READ, 3'h0, 4'hA, 8'h00, 1'b0, 0);
        chk(m_bits, {8'h0, 1'b1, REQ_READ, 4'hA, 1'b0});
        chk(17'(m_len), 17'(LEN_READ));
        send(REQ_WRITE, 3'h0, 4'h5, 8'hC3, 1'b0, 0);
        chk(m_bits, {1'b1, REQ_WRITE, 4'h5, 8'hC3, 1'b0});
        chk(17'({m_len, phy_u.regs[5]}), 17'({LEN_WRITE, 8'hC3}));
    endtask
    task automatic t_bus;
        logic [2:0] sp [4] = '{SPD_S100, SPD_S200, SPD_S400, 3'h3};
        logic [7:0] c;
        for (int i = 0; i < 4; i++) begin
            send(REQ_IMM, sp[i], 4'h0, 8'h00, 1'b0, 3);
            if (sp[i][0]) chk(m_bits, {9'h0, 1'b1, REQ_IMM, sp[i], 1'b0});
            else chk(m_bits, {10'h0, 1'b1, REQ_IMM, sp[i]});
            chk(17'({pending, m_pend}), 17'h3);
            c = m_cnt;
            send(REQ_PRI, SPD_S100, 4'h0, 8'h00, 1'b0, 0);
            chk(17'(m_cnt), 17'(c));
            grant(i == 3);
        end
    endtask
    task automatic t_clear;
        logic [7:0] c;
        send(REQ_FAIR, SPD_S200, 4'h0, 8'h00, 1'b0, 0);
        chk(17'({pending, m_pend}), 17'h3);
        rx = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        rx = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk(17'({pending, m_pend}), 17'h0);
        c = m_cnt;
        send(REQ_PRI, SPD_S100, 4'h0, 8'h00, 1'b0, 3);
        // the spoiled stream and its resend both reach the device
        chk(17'({pending, m_pend, m_cnt}), 17'({2'h3, 8'(c + 8'h02)}));
        bus_rst = 1'b1;
        @(negedge sys_clk_i);
        bus_rst = 1'b0;
        cyc_start = 1'b1;
        @(negedge sys_clk_i);
        cyc_start = 1'b0;
        send(REQ_ISO, SPD_S400, 4'h0, 8'h00, 1'b0, 4);
        // receive while the isochronous request is pending must not clear it
        rx = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        rx = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk(17'({pending, m_pend}), 17'h3);
        bus_rst = 1'b1;
        @(negedge sys_clk_i);
        bus_rst = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk(17'({pending, m_pend}), 17'h0);
    endtask
    task automatic t_rsvd;
        logic [7:0] c;
        c = m_cnt;
        send(REQ_RSVD, 3'h0, 4'h3, 8'hFF, 1'b1, 0);
        repeat (20) @(negedge sys_clk_i);
        chk(17'({m_cnt, ready, pending}), 17'({c, 2'h2}));
    endtask
    initial begin
        repeat (20) @(negedge sys_clk_i);
        reset_i = 1'b0;
        chk(17'({ready, pending, granted, ctl_oe_n, line_o}), 17'h26);
        mon_on = 1'b1;
        t_regs();
        t_bus();
        t_clear();
        t_rsvd();
        mon_on = 1'b0;
        iso_n = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        mon_on = 1'b1;
        t_regs();
        complete_run();
    end
endmodule
